//--- rtl/fsps_top.sv
// Flash self-programming sequencer with APB register access
//
// Our own choices: the placing of the registers and the APB interface to the registers.
module fsps_top #(
  parameter int PROG_CYC = fsps_pkg::PROG_CYCLES,
  parameter int WORDS    = 64
) (
  input  wire logic        core_clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        eeprom_write_busy,
  input  wire logic [7:0]  fuse_low_byte,
  input  wire logic [7:0]  fuse_high_byte,
  input  wire logic [7:0]  fuse_extended_byte,
  input  wire logic [15:0] flash_rd_word,
  output logic             irq,
  output logic             core_halt,
  output logic             rww_read_block,
  output logic             flash_erase,
  output logic             flash_write,
  output logic [6:0]       flash_page,
  output logic [15:0]      flash_wr_word,
  output logic [5:0]       flash_wr_index
);
  logic [7:0]  ctrl_q, ctrl_d;
  logic [15:0] ptr_q, ptr_d;
  logic [15:0] data_q, data_d;
  logic [7:0]  lock_q, lock_d;
  logic [7:0]  ldres_q, ldres_d;
  logic [2:0]  win_q, win_d;
  logic [31:0] cnt_q, cnt_d;
  logic [1:0]  op_q, op_d;
  fsps_pkg::fsps_state_type st_q, st_d;
  logic [15:0] buf_q [WORDS];
  logic [WORDS-1:0] bval_q, bval_d;
  logic        buf_we;
  logic [31:0] prdata_d;
  logic        pslverr_d, pready_d;
  logic        irq_d, halt_d, blk_d, ers_d, wrt_d;
  logic [6:0]  page_q, page_d;
  logic        busy_q, busy_d;
  logic        wr_acc, rd_acc, store, ldreq;
  logic [6:0]  cmd;

  assign wr_acc = psel && penable && pwrite && pready == 1'b0;
  assign rd_acc = psel && penable && !pwrite && pready == 1'b0;
  assign store  = wr_acc && paddr == fsps_pkg::ADDR_STORE;
  assign ldreq  = wr_acc && paddr == fsps_pkg::ADDR_LDREQ;
  assign cmd    = ctrl_q[6:0] & 7'h1f | {2'b00, ctrl_q[4], 4'h0};
  assign buf_we = st_q == fsps_pkg::FSPS_ARMED && store && ctrl_q[3:0] == 4'h1
                  && !eeprom_write_busy;

  // Sequencer and register state
  always_comb begin
    ctrl_d  = ctrl_q;
    ptr_d   = ptr_q;
    data_d  = data_q;
    lock_d  = lock_q;
    ldres_d = ldres_q;
    win_d   = win_q;
    cnt_d   = cnt_q;
    op_d    = op_q;
    st_d    = st_q;
    bval_d  = bval_q;
    page_d  = page_q;
    busy_d  = busy_q;
    ers_d   = 1'b0;
    wrt_d   = 1'b0;
    if (eeprom_write_busy && bval_q != '0) begin
      bval_d = '0;
    end
    unique case (st_q)
      fsps_pkg::FSPS_IDLE: begin
        if (ldreq) begin
          ldres_d = ptr_q[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
        end
        if (wr_acc && paddr == fsps_pkg::ADDR_CTRL && pstrb[0] && !eeprom_write_busy) begin
          ctrl_d[7] = pwdata[7];
          ctrl_d[4:0] = pwdata[4:0];
          if (pwdata[0]) begin
            st_d  = fsps_pkg::FSPS_ARMED;
            win_d = 3'(fsps_pkg::STORE_WINDOW);
          end
        end else if (wr_acc && paddr == fsps_pkg::ADDR_CTRL && pstrb[0]) begin
          ctrl_d[7] = pwdata[7];
        end
      end
      fsps_pkg::FSPS_ARMED: begin
        win_d = win_q - 3'd1;
        if (store && !eeprom_write_busy) begin
          st_d = fsps_pkg::FSPS_IDLE;
          ctrl_d[4:0] = 5'h00;
          if (cmd == fsps_pkg::CMD_ERASE || cmd == fsps_pkg::CMD_WRITE) begin
            page_d = ptr_q[fsps_pkg::PAGE_MSB:fsps_pkg::PAGE_LSB];
            ers_d  = cmd == fsps_pkg::CMD_ERASE;
            wrt_d  = cmd == fsps_pkg::CMD_WRITE;
            busy_d = page_d < fsps_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE ? 1'b1 : busy_q;
            op_d   = cmd == fsps_pkg::CMD_WRITE ? 2'd2 : 2'd1;
            st_d   = fsps_pkg::FSPS_PROG;
            cnt_d  = 32'(PROG_CYC);
            ctrl_d[4:0] = {2'b00, ctrl_q[2:1], 1'b1};
          end else if (cmd == fsps_pkg::CMD_LOCK) begin
            lock_d = {lock_q[7:6], lock_q[5:0] & data_q[5:0]};
            op_d   = 2'd3;
            st_d   = fsps_pkg::FSPS_PROG;
            cnt_d  = 32'(PROG_CYC);
            ctrl_d[4:0] = {1'b0, ctrl_q[3], 2'b00, 1'b1};
          end else if (cmd == fsps_pkg::CMD_LOAD) begin
            bval_d[ptr_q[fsps_pkg::WORD_MSB:fsps_pkg::WORD_LSB]] = 1'b1;
          end else if (cmd == fsps_pkg::CMD_REEN) begin
            busy_d = 1'b0;
            bval_d = '0;
          end
        end else if (ldreq && ctrl_q[3] && win_q > 3'(fsps_pkg::STORE_WINDOW - fsps_pkg::LOAD_WINDOW)
                     && !eeprom_write_busy) begin
          unique case (ptr_q)
            fsps_pkg::PTR_LOCK:     ldres_d = lock_q;
            fsps_pkg::PTR_FUSE_LO:  ldres_d = fuse_low_byte;
            fsps_pkg::PTR_FUSE_HI:  ldres_d = fuse_high_byte;
            fsps_pkg::PTR_FUSE_EXT: ldres_d = fuse_extended_byte;
            default:                ldres_d = 8'hff;
          endcase
          ctrl_d[4:0] = 5'h00;
          st_d = fsps_pkg::FSPS_IDLE;
        end else if (ldreq) begin
          ldres_d = ptr_q[0] ? flash_rd_word[15:8] : flash_rd_word[7:0];
        end else if (win_q == 3'd1) begin
          ctrl_d[4:0] = 5'h00;
          st_d = fsps_pkg::FSPS_IDLE;
        end
      end
      fsps_pkg::FSPS_PROG: begin
        cnt_d = cnt_q - 32'd1;
        if (wr_acc && paddr == fsps_pkg::ADDR_CTRL && pstrb[0]) begin
          ctrl_d[7] = pwdata[7];
        end
        if (cnt_q == 32'd1) begin
          st_d = fsps_pkg::FSPS_IDLE;
          ctrl_d[4:0] = 5'h00;
          if (op_q == 2'd2) begin
            bval_d = '0;
          end
          op_d = 2'd0;
        end
      end
      default: st_d = fsps_pkg::FSPS_IDLE;
    endcase
    if (wr_acc && paddr == fsps_pkg::ADDR_POINTER) begin
      ptr_d = pwdata[15:0];
    end
    if (wr_acc && paddr == fsps_pkg::ADDR_DATA) begin
      data_d = pwdata[15:0];
    end
  end

  // Outputs and bus answer
  always_comb begin
    prdata_d  = 32'h0000_0000;
    pslverr_d = 1'b0;
    pready_d  = psel && penable && !pready;
    irq_d     = ctrl_d[7] && !ctrl_d[0];
    halt_d    = st_d == fsps_pkg::FSPS_PROG && op_d != 2'd3
                && page_d >= fsps_pkg::NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;
    blk_d     = busy_d;
    if (rd_acc) begin
      unique case (paddr)
        fsps_pkg::ADDR_CTRL:    prdata_d = {24'h0, ctrl_q[7], busy_q, 1'b0, ctrl_q[4:0]};
        fsps_pkg::ADDR_POINTER: prdata_d = {16'h0, ptr_q};
        fsps_pkg::ADDR_DATA:    prdata_d = {16'h0, data_q};
        fsps_pkg::ADDR_LDDATA:  prdata_d = {24'h0, ldres_q};
        fsps_pkg::ADDR_FUSE:    prdata_d = {24'h0, lock_q};
        default:                pslverr_d = 1'b1;
      endcase
    end else if (wr_acc) begin
      pslverr_d = !(paddr == fsps_pkg::ADDR_CTRL || paddr == fsps_pkg::ADDR_POINTER
                    || paddr == fsps_pkg::ADDR_DATA || paddr == fsps_pkg::ADDR_LDREQ
                    || paddr == fsps_pkg::ADDR_STORE);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      // running program timer and page survive reset
      ctrl_q  <= (st_q == fsps_pkg::FSPS_PROG) ? {1'b0, ctrl_q[6:0]} : fsps_pkg::CTRL_RESET;
      st_q    <= (st_q == fsps_pkg::FSPS_PROG) ? st_d : fsps_pkg::FSPS_IDLE;
      cnt_q   <= cnt_d;
      op_q    <= (st_q == fsps_pkg::FSPS_PROG) ? op_d : 2'd0;
      busy_q  <= busy_d;
      page_q  <= page_q;
      ptr_q   <= 16'h0000;
      data_q  <= 16'h0000;
      ldres_q <= 8'h00;
      win_q   <= 3'd0;
      bval_q  <= '0;
      lock_q  <= 8'hff;
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
      // Halt follows the surviving operation, not the reset
      core_halt      <= halt_d;
      rww_read_block <= busy_d;
      flash_erase    <= 1'b0;
      flash_write    <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      op_q    <= op_d;
      busy_q  <= busy_d;
      page_q  <= page_d;
      ptr_q   <= ptr_d;
      data_q  <= data_d;
      ldres_q <= ldres_d;
      win_q   <= win_d;
      bval_q  <= bval_d;
      lock_q  <= lock_d;
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
      irq     <= irq_d;
      core_halt      <= halt_d;
      rww_read_block <= blk_d;
      flash_erase    <= ers_d;
      flash_write    <= wrt_d;
    end
  end

  // Buffer words; flash sees the one word at the pointer's write index, 16'hffff if not loaded
  always_ff @(posedge core_clk) begin
    if (buf_we) begin
      buf_q[ptr_q[fsps_pkg::WORD_MSB:fsps_pkg::WORD_LSB]] <= data_q;
    end
    flash_page     <= srst ? page_q : page_d;
    flash_wr_index <= ptr_q[fsps_pkg::WORD_MSB:fsps_pkg::WORD_LSB];
    flash_wr_word  <= bval_q[ptr_q[fsps_pkg::WORD_MSB:fsps_pkg::WORD_LSB]]
                      ? buf_q[ptr_q[fsps_pkg::WORD_MSB:fsps_pkg::WORD_LSB]] : 16'hffff;
  end

  AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (srst)
    irq == (ctrl_q[7] && !ctrl_q[0])) else $error("irq not raised");
  AST_BUSY_BLOCK: assert property (@(posedge core_clk) disable iff (srst)
    busy_q |-> rww_read_block) else $error("rww not blocked");
  AST_LOCK_NOHALT: assert property (@(posedge core_clk) disable iff (srst)
    op_q == 2'd3 |-> !core_halt) else $error("halt during lock");
  AST_EN_DURING_PROG: assert property (@(posedge core_clk) disable iff (srst)
    st_q == fsps_pkg::FSPS_PROG |-> ctrl_q[0]) else $error("enable dropped");
  AST_WIN_EXPIRE: assert property (@(posedge core_clk) disable iff (srst)
    $rose(st_q == fsps_pkg::FSPS_ARMED) |-> ##[1:5] st_q != fsps_pkg::FSPS_ARMED)
    else $error("window overrun");
  AST_EE_BLOCK: assert property (@(posedge core_clk) disable iff (srst)
    st_q == fsps_pkg::FSPS_IDLE && eeprom_write_busy |=> st_q != fsps_pkg::FSPS_ARMED)
    else $error("armed during eeprom");
  AST_EE_DISCARD: assert property (@(posedge core_clk) disable iff (srst)
    eeprom_write_busy |=> bval_q == '0) else $error("buffer kept");
  AST_REEN_CLEAR: assert property (@(posedge core_clk) disable iff (srst)
    st_q == fsps_pkg::FSPS_ARMED && store && cmd == fsps_pkg::CMD_REEN && !eeprom_write_busy
    |=> !busy_q && bval_q == '0) else $error("re-enable failed");
endmodule

//--- rtl/fsps_pkg.sv
// Constants for the flash self-programming sequencer
package fsps_pkg;
  localparam logic [11:0] ADDR_CTRL     = 12'h000;
  localparam logic [11:0] ADDR_POINTER  = 12'h004;
  localparam logic [11:0] ADDR_DATA     = 12'h008;
  localparam logic [11:0] ADDR_LDREQ    = 12'h00c;
  localparam logic [11:0] ADDR_LDDATA   = 12'h010;
  localparam logic [11:0] ADDR_STORE    = 12'h014;
  localparam logic [11:0] ADDR_FUSE     = 12'h018;
  localparam int BIT_IRQ_EN  = 7;
  localparam int BIT_BUSY    = 6;
  localparam int BIT_REEN    = 4;
  localparam int BIT_LOCKSET = 3;
  localparam int BIT_PGWR    = 2;
  localparam int BIT_PGER    = 1;
  localparam int BIT_EN      = 0;
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [6:0] CMD_ERASE    = 7'h03;
  localparam logic [6:0] CMD_LOAD     = 7'h01;
  localparam logic [6:0] CMD_WRITE    = 7'h05;
  localparam logic [6:0] CMD_LOCK     = 7'h09;
  localparam logic [6:0] CMD_REEN     = 7'h11;
  localparam logic [15:0] PTR_FUSE_LO  = 16'h0000;
  localparam logic [15:0] PTR_LOCK     = 16'h0001;
  localparam logic [15:0] PTR_FUSE_EXT = 16'h0002;
  localparam logic [15:0] PTR_FUSE_HI  = 16'h0003;
  localparam int PAGE_MSB = 13;
  localparam int PAGE_LSB = 7;
  localparam int WORD_MSB = 6;
  localparam int WORD_LSB = 1;
  localparam int STORE_WINDOW = 4;
  localparam int LOAD_WINDOW  = 3;
  localparam int CLK_MHZ      = 50;
  localparam int PROG_MIN_US  = 3700;
  localparam int PROG_MAX_US  = 4500;
  localparam int PROG_CYCLES  = PROG_MIN_US * CLK_MHZ;
  localparam logic [6:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h70;
  typedef enum logic [1:0] {
    FSPS_IDLE  = 2'b00,
    FSPS_ARMED = 2'b01,
    FSPS_PROG  = 2'b10
  } fsps_state_type;
endpackage

//--- tb/fsps_flash_model.sv
// Flash array and fuse stand-in on the sequencer's flash side
module fsps_flash_model #(
  parameter logic [15:0] RD_WORD = 16'h5a3c,
  parameter logic [7:0]  F_LO    = 8'hd2,
  parameter logic [7:0]  F_HI    = 8'h9b,
  parameter logic [7:0]  F_EXT   = 8'hfd
) (
  input  wire logic  core_clk,
  input  wire logic  flash_erase,
  input  wire logic  flash_write,
  output logic [15:0] flash_rd_word,
  output logic [7:0]  fuse_low_byte,
  output logic [7:0]  fuse_high_byte,
  output logic [7:0]  fuse_extended_byte,
  output int          erase_cnt,
  output int          write_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  // Fuse values are arbitrary; zero bits stand for programmed
  assign fuse_low_byte      = F_LO;
  assign fuse_high_byte     = F_HI;
  assign fuse_extended_byte = F_EXT;
  assign flash_rd_word      = RD_WORD;
  initial begin
    erase_cnt = 0;
    write_cnt = 0;
  end
  always @(posedge core_clk) begin
    if (flash_erase === 1'b1) erase_cnt++;
    if (flash_write === 1'b1) write_cnt++;
  end
endmodule

//--- tb/fsps_top_tb.sv
// Register-level bench for the flash self-programming sequencer
module fsps_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, srst, psel, penable, pwrite, ee, pready, pslverr, err;
  logic        irq, core_halt, rww_read_block, flash_erase, flash_write;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [7:0]  flo, fhi, fext;
  logic [15:0] rdw, wrw;
  logic [6:0]  flash_page;
  logic [5:0]  wri;
  int          bad_count, n_tests, ecnt, wcnt, i;
  fsps_top #(.PROG_CYC(20)) uut (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .eeprom_write_busy(ee),
    .fuse_low_byte(flo), .fuse_high_byte(fhi), .fuse_extended_byte(fext),
    .flash_rd_word(rdw), .irq(irq), .core_halt(core_halt),
    .rww_read_block(rww_read_block), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_page(flash_page), .flash_wr_word(wrw),
    .flash_wr_index(wri));
  fsps_flash_model fm (.core_clk(core_clk), .flash_erase(flash_erase),
    .flash_write(flash_write), .flash_rd_word(rdw), .fuse_low_byte(flo),
    .fuse_high_byte(fhi), .fuse_extended_byte(fext), .erase_cnt(ecnt), .write_cnt(wcnt));
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Leaves the bus selected so a following transfer can start at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (k == 40) begin
      bad_count++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  // Eeprom busy is low whenever control is written here
  task automatic prog(input logic [15:0] p, input logic [7:0] c);
    apb(1, fsps_pkg::ADDR_POINTER, {16'h0, p});
    apb(1, fsps_pkg::ADDR_CTRL, {24'h0, c});
    apb(1, fsps_pkg::ADDR_STORE, 32'h0);
    idle();
  endtask
  task automatic fread(input logic [15:0] p);
    apb(1, fsps_pkg::ADDR_POINTER, {16'h0, p});
    apb(1, fsps_pkg::ADDR_CTRL, 32'h09);
    apb(1, fsps_pkg::ADDR_LDREQ, 32'h0);
    apb(0, fsps_pkg::ADDR_LDDATA, 32'h0);
    idle();
  endtask
  task automatic wait_done();
    int k;
    for (k = 0; k < 60; k++) begin
      apb(0, fsps_pkg::ADDR_CTRL, 32'h0);
      if (rd[0] === 1'b0) break;
    end
    idle();
    chk("op_done", k < 60, 1'b1);
  endtask
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    {srst, psel, penable, pwrite, ee, paddr, pwdata} = {1'b1, 4'h0, 12'h0, 32'h0};
    pstrb = 4'hf;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    apb(0, fsps_pkg::ADDR_CTRL, 32'h0);
    chk("ctrl_reset", rd, 32'h0);
    apb(0, 12'h01c, 32'h0);
    chk("unmapped_err", err, 1'b1);
    idle();
    fread(16'h0000);
    chk("fuse_lo", rd[7:0], 8'hd2);
    fread(16'h0003);
    chk("fuse_hi", rd[7:0], 8'h9b);
    fread(16'h0002);
    chk("fuse_ext", rd[7:0], 8'hfd);
    apb(1, fsps_pkg::ADDR_CTRL, 32'h09);
    idle();
    repeat (6) @(posedge core_clk);
    apb(0, fsps_pkg::ADDR_CTRL, 32'h0);
    chk("selfclear", rd[3:0], 4'h0);
    apb(1, fsps_pkg::ADDR_LDREQ, 32'h0);
    apb(0, fsps_pkg::ADDR_LDDATA, 32'h0);
    chk("plain_load", rd, 32'h3c);
    ee <= 1'b1;
    apb(1, fsps_pkg::ADDR_CTRL, 32'h09);
    apb(0, fsps_pkg::ADDR_CTRL, 32'h0);
    chk("ee_block", rd[7:0], 8'h00);
    ee <= 1'b0;
    idle();
    prog({2'b0, 7'h10, 6'h3f, 1'b1}, 8'h83);
    chk("erase_pulse", ecnt, 1);
    chk("erase_page", flash_page, 7'h10);
    chk("rww_blk", {rww_read_block, core_halt}, 2'b10);
    apb(0, fsps_pkg::ADDR_CTRL, 32'h0);
    chk("busy_en", {rd[6], rd[0], irq}, 3'b110);
    wait_done();
    chk("irq_done", irq, 1'b1);
    apb(0, fsps_pkg::ADDR_CTRL, 32'h0);
    chk("busy_hold", rd[6], 1'b1);
    prog(16'h0, 8'h11);
    chk("reenable", rww_read_block, 1'b0);
    for (i = 0; i < 2; i++) begin
      apb(1, fsps_pkg::ADDR_DATA, i ? 32'hbeef : 32'h1234);
      prog({2'b0, 7'h10, 6'd5, 1'b0}, 8'h01);
      chk("buf_word", {wri, wrw}, {6'd5, i ? 16'hbeef : 16'h1234});
      if (i == 0) begin
        ee <= 1'b1;
        idle();
        ee <= 1'b0;
        repeat (2) idle();
        chk("ee_discard", wrw, 16'hffff);
      end
    end
    prog({2'b0, 7'h10, 7'h0}, 8'h05);
    chk("write_cnt", wcnt, 32'd1);
    chk("write", {flash_page, rww_read_block}, {7'h10, 1'b1});
    wait_done();
    apb(1, fsps_pkg::ADDR_POINTER, {16'h0, 2'b0, 7'h10, 6'd5, 1'b0});
    idle();
    idle();
    chk("buf_clear", wrw, 16'hffff);
    prog(16'h0, 8'h11);
    prog({2'b0, 7'h70, 7'h0}, 8'h03);
    chk("no_read_while_write_section_halt", core_halt, 1'b1);
    srst <= 1'b1;
    idle();
    srst <= 1'b0;
    idle();
    chk("rst_keeps", core_halt, 1'b1);
    for (i = 0; i < 60 && core_halt !== 1'b0; i++) idle();
    chk("no_read_while_write_section_end", i < 60, 1'b1);
    prog(16'h0, 8'h11);
    // Bits 7:6 kept high, pointer at the lock address
    apb(1, fsps_pkg::ADDR_DATA, 32'hfc);
    prog(16'h0001, 8'h09);
    chk("lock_noblk", {rww_read_block, core_halt}, 2'b00);
    wait_done();
    fread(16'h0001);
    chk("lock_byte", rd[7:0], 8'hfc);
    test_done();
  end
endmodule
